// ---- logic/irq_ctrl_defs.svh ----
// offsets, reset values, vectors, source numbers and edge codes of the interrupt controller
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH
`define OFS_GLOBAL_CTRL   12'h000
`define OFS_GROUP_CTRL    12'h004
`define OFS_EDGE_SEL      12'h008
`define OFS_TIMER_MATCH   12'h00C
`define OFS_EE_LOWVOLT    12'h010
`define OFS_STATUS        12'h014
`define OFS_VECTOR_BASE   12'h018
`define RST_REG8          8'h00
`define RST_VEC_BASE      12'h004
`define VEC_STEP          12'h004
`define N_SRC             5
`define SRC_PIN0          3'h0
`define SRC_PIN1          3'h1
`define SRC_GRP0          3'h2
`define SRC_GRP1          3'h3
`define SRC_GRP2          3'h4
`define EDGE_OFF          2'h0
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3
`define STACK_DEPTH       4'h8
`endif

// ---- logic/irq_ctrl_pkg.sv ----
// types shared by the interrupt controller
package irq_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ENTRY = 2'b01,
        ST_SLEEP = 2'b10
    } seq_state_t;

    // core sequencer request towards the controller
    typedef struct packed {
        logic [11:0] next_pc;
        logic        insn_boundary;
        logic        return_from_irq;
        logic        sleep;
    } core_req_t;

    // controller answer to the core sequencer
    typedef struct packed {
        logic        push;
        logic [11:0] push_data;
        logic        load_pc;
        logic [11:0] pc_value;
        logic        pop;
        logic        wake;
    } core_ans_t;
endpackage

// ---- logic/irq_ctrl.sv ----
// vectored interrupt controller with pin edges, grouped sources and pc stack
// Operation
// - source events set flags regardless of enables, except pin edges, which need the pin enable
// - disabled flag stays set, never jumps
// - global enable low blocks all jumps
// - entry pushes next pc, loads vector
// - return pops saved pc to resume
// - entry clears global enable automatically
// - requests during service still latch flags
// - full stack defers acknowledge, flag pending
// - any flag setting wakes sleep or idle
// - each pin sets flag on selected edge
// - edge select: off, rise, fall, both
// - pin is interrupt input only when enabled
// - pin service clears its flag and global
// - pull-high stays active in interrupt use
// - three shared groups aggregate existing sources
// - member flag set raises group flag
// - group service clears group flag, global
// - member flags stay set, software clears all but group 0's
// - timer register fields b,a,p bits 6-4, 2-0
// - eeprom/lowvolt fields bits 5,4 and 1,0
//
// The register addresses and the APB slave port were chosen for this implementation.
`include "irq_ctrl_defs.svh"
module irq_ctrl (
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    input  wire logic                   PSEL_I,
    input  wire logic                   PENABLE_I,
    input  wire logic                   PWRITE_I,
    input  wire logic [11:0]            PADDR_I,
    input  wire logic [31:0]            PWDATA_I,
    output logic      [31:0]            PRDATA_O,
    output logic                        PREADY_O,
    output logic                        PSLVERR_O,
    input  wire logic [1:0]             PIN_I,
    input  wire logic [1:0]             PIN_PULLUP_SEL_I,
    output logic      [1:0]             PIN_PULLUP_EN_O,
    output logic      [1:0]             PIN_IRQ_MODE_O,
    input  wire logic [2:0]             TIMER_MATCH_I,
    input  wire logic [2:0]             GROUP0_EVT_I,
    input  wire logic                   EEPROM_DONE_I,
    input  wire logic                   LOWVOLT_I,
    input  wire irq_ctrl_pkg::core_req_t CORE_REQ_I,
    output irq_ctrl_pkg::core_ans_t     CORE_ANS_O,
    output logic [2:0]                  STACK_PTR_O
);
    // flags share the layout of their registers: pending bits in the upper nibble, enables in the lower
    logic [7:0]  global_q;        // bit0 global enable, bits1..2 pin enables, bits4..5 pin flags
    logic [7:0]  group_q;         // bits0..2 group enables, bits4..6 group flags
    logic [3:0]  edge_sel_q;
    logic [7:0]  timer_q;
    logic [7:0]  ee_lv_q;
    logic [7:0]  grp0_q;          // latched members of group 0, read-only in bits 14..12 of the status word
    logic [11:0] vec_base_q;
    logic [3:0]  sp_q;
    logic [1:0]  pin_s1_q;
    logic [1:0]  pin_s2_q;
    logic [1:0]  pin_prev_q;
    logic        ee_s1_q;
    logic        ee_s2_q;
    logic        lv_s1_q;
    logic        lv_s2_q;
    logic        lv_prev_q;
    logic        ee_prev_q;
    logic [31:0] prdata_q;
    irq_ctrl_pkg::seq_state_t state_q;
    logic [11:0] vec_q;           // vector of the source being entered, held for the load

    logic        wr_en;
    logic        rd_en;
    logic [1:0]  pin_evt;
    logic [2:0]  tm_evt;
    logic        ee_evt;
    logic        lv_evt;
    logic [2:0]  grp_set;
    logic [4:0]  pending;
    logic        take;
    logic [2:0]  take_src;
    logic        stack_full;
    logic        any_set;
    logic        pop_ok;
    logic        wr_global;
    logic        wr_group;
    logic        wr_edge;
    logic        wr_timer;
    logic        wr_ee_lv;
    logic        wr_vec;

    // one edge detector per pin, decoding its two select bits
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        case (sel)
            `EDGE_RISE: edge_hit = !prev && cur;
            `EDGE_FALL: edge_hit = prev && !cur;
            `EDGE_BOTH: edge_hit = prev != cur;
            default:    edge_hit = 1'b0;
        endcase
    endfunction

    // fixed priority: pin0, pin1, group0, group1, group2
    function automatic logic [2:0] pick(input logic [4:0] req);
        pick = `SRC_GRP2;
        for (int i = `N_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick = 3'(i);
            end
        end
    endfunction

    // rising edge of a synchronised level; eeprom and low-voltage share it
    function automatic logic rose_edge(input logic prev, input logic cur);
        rose_edge = !prev && cur;
    endfunction

    // write strobe of one register: access phase of a write to its offset
    function automatic logic wr_hit(input logic en, input logic [11:0] addr,
                                    input logic [11:0] ofs);
        wr_hit = en && addr == ofs;
    endfunction

    // apb decode: zero wait states, every access completes in its access phase
    assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en     = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && (PADDR_I > `OFS_VECTOR_BASE || PADDR_I[1:0] != 2'h0);
    assign PRDATA_O  = prdata_q;

    // one strobe per writable register, so every offset is decoded once
    // unmapped or unaligned accesses change nothing and read zero
    assign wr_global = wr_hit(wr_en, PADDR_I, `OFS_GLOBAL_CTRL);
    assign wr_group  = wr_hit(wr_en, PADDR_I, `OFS_GROUP_CTRL);
    assign wr_edge   = wr_hit(wr_en, PADDR_I, `OFS_EDGE_SEL);
    assign wr_timer  = wr_hit(wr_en, PADDR_I, `OFS_TIMER_MATCH);
    assign wr_ee_lv  = wr_hit(wr_en, PADDR_I, `OFS_EE_LOWVOLT);
    assign wr_vec    = wr_hit(wr_en, PADDR_I, `OFS_VECTOR_BASE);

    // pins, eeprom and low-voltage events come from other domains
    // previous-value flops reset to the idle low level, so no false edge follows reset
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pin_s1_q   <= 2'h0;
            pin_s2_q   <= 2'h0;
            pin_prev_q <= 2'h0;
            ee_s1_q    <= 1'b0;
            ee_s2_q    <= 1'b0;
            ee_prev_q  <= 1'b0;
            lv_s1_q    <= 1'b0;
            lv_s2_q    <= 1'b0;
            lv_prev_q  <= 1'b0;
        end else begin
            pin_s1_q   <= PIN_I;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            ee_s1_q    <= EEPROM_DONE_I;
            ee_s2_q    <= ee_s1_q;
            ee_prev_q  <= ee_s2_q;
            lv_s1_q    <= LOWVOLT_I;
            lv_s2_q    <= lv_s1_q;
            lv_prev_q  <= lv_s2_q;
        end
    end

    // a pin counts as interrupt input only while its enable is set
    // the pull-up select passes straight through, interrupt use or not
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            assign PIN_IRQ_MODE_O[g] = global_q[1 + g];
            assign pin_evt[g] = global_q[1 + g] && edge_hit(edge_sel_q[2*g +: 2],
                                pin_prev_q[g], pin_s2_q[g]);
            assign PIN_PULLUP_EN_O[g] = PIN_PULLUP_SEL_I[g];
        end
    endgenerate

    // timer matches are same-domain pulses; eeprom and low-voltage are rising edges
    assign tm_evt = TIMER_MATCH_I;
    assign ee_evt = rose_edge(ee_prev_q, ee_s2_q);
    assign lv_evt = rose_edge(lv_prev_q, lv_s2_q);

    // group flag rises when any member event sets its flag; a software write to a member flag does not raise it
    assign grp_set[0] = |GROUP0_EVT_I;
    assign grp_set[1] = |tm_evt;
    assign grp_set[2] = ee_evt || lv_evt;

    // request vector, masked by each individual enable
    assign pending = {group_q[6] && group_q[2], group_q[5] && group_q[1],
                      group_q[4] && group_q[0], global_q[5] && global_q[2],
                      global_q[4] && global_q[1]};
    // a full stack leaves the request pending until a return frees a slot
    assign stack_full = sp_q == `STACK_DEPTH;
    // entry only from run: never in the entry cycle itself, never while asleep
    assign take = state_q == irq_ctrl_pkg::ST_RUN && CORE_REQ_I.insn_boundary
                  && global_q[0] && |pending && !stack_full;
    // lowest index wins: pins first, then the groups in order
    assign take_src = pick(pending);
    // a return only pops what was pushed; an empty stack ignores it
    assign pop_ok = CORE_REQ_I.return_from_irq && sp_q != 4'h0;
    // sleep ends on any new event, group enabled or not; pin edges count only with the pin enable
    assign any_set = |pin_evt || |tm_evt || ee_evt || lv_evt || |GROUP0_EVT_I;

    // global, pin enables and pin flags; hardware set beats software clear
    // a write replaces the byte; entry clears and event sets are applied after it
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            global_q <= `RST_REG8;
        end else begin
            logic [7:0] nxt;
            nxt = global_q;
            if (wr_global) begin
                nxt = PWDATA_I[7:0] & 8'h37;
            end
            if (take) begin
                nxt[0] = 1'b0;
                if (take_src == `SRC_PIN0) begin
                    nxt[4] = 1'b0;
                end
                if (take_src == `SRC_PIN1) begin
                    nxt[5] = 1'b0;
                end
            end
            if (pin_evt[0]) begin
                nxt[4] = 1'b1;
            end
            if (pin_evt[1]) begin
                nxt[5] = 1'b1;
            end
            global_q <= nxt;
        end
    end

    // group flags and enables; members are left untouched on service
    // software clears the timer and eeprom/low-voltage member flags itself; group 0 members clear only on reset
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            group_q <= `RST_REG8;
        end else begin
            logic [7:0] nxt;
            nxt = group_q;
            if (wr_group) begin
                nxt = PWDATA_I[7:0] & 8'h77;
            end
            for (int i = 0; i < 3; i++) begin
                if (take && take_src == `SRC_GRP0 + 3'(i)) begin
                    nxt[4 + i] = 1'b0;
                end
                if (grp_set[i]) begin
                    nxt[4 + i] = 1'b1;
                end
            end
            group_q <= nxt;
        end
    end

    // member flag registers: bits 7 and 3 of timer, 7..6 and 3..2 of the other read zero
    // a software clear loses against an event in the same cycle
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            timer_q <= `RST_REG8;
            ee_lv_q <= `RST_REG8;
            grp0_q  <= `RST_REG8;
        end else begin
            logic [7:0] t;
            logic [7:0] e;
            t = timer_q;
            e = ee_lv_q;
            if (wr_timer) begin
                t = PWDATA_I[7:0] & 8'h77;
            end
            if (wr_ee_lv) begin
                e = PWDATA_I[7:0] & 8'h33;
            end
            t[6:4] = t[6:4] | {tm_evt[2], tm_evt[1], tm_evt[0]};
            e[5]   = e[5] | ee_evt;
            e[4]   = e[4] | lv_evt;
            timer_q <= t;
            ee_lv_q <= e;
            grp0_q  <= {1'b0, grp0_q[6:4] | GROUP0_EVT_I, 4'h0};
        end
    end

    // vector base register
    // vectors step one word per source from this base, lowest source first
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            vec_base_q <= `RST_VEC_BASE;
        end else if (wr_vec) begin
            vec_base_q <= PWDATA_I[11:0];
        end
    end

    // entry sequencing and stack pointer tracking
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q    <= irq_ctrl_pkg::ST_RUN;
            vec_q      <= 12'h000;
            sp_q       <= 4'h0;
        end else begin
            case (state_q)
                irq_ctrl_pkg::ST_RUN: begin
                    if (take) begin
                        state_q    <= irq_ctrl_pkg::ST_ENTRY;
                        vec_q      <= vec_base_q + 12'(take_src) * `VEC_STEP;
                    end else if (CORE_REQ_I.sleep) begin
                        state_q <= irq_ctrl_pkg::ST_SLEEP;
                    end
                end
                irq_ctrl_pkg::ST_ENTRY: begin
                    state_q <= irq_ctrl_pkg::ST_RUN;
                end
                irq_ctrl_pkg::ST_SLEEP: begin
                    if (any_set) begin
                        state_q <= irq_ctrl_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_q <= irq_ctrl_pkg::ST_RUN;
                end
            endcase
            // a push and a pop in one cycle leave the depth as it is
            if (take && !pop_ok) begin
                sp_q <= sp_q + 4'h1;
            end else if (pop_ok && !take) begin
                sp_q <= sp_q - 4'h1;
            end
        end
    end

    // core answer: push in the take cycle, vector load in the entry cycle
    // push and pop are handshakes and stay combinational; the vector comes from a flop
    always_comb begin
        CORE_ANS_O           = '0;
        CORE_ANS_O.push      = take;
        CORE_ANS_O.push_data = CORE_REQ_I.next_pc;
        CORE_ANS_O.load_pc   = state_q == irq_ctrl_pkg::ST_ENTRY;
        CORE_ANS_O.pc_value  = vec_q;
        CORE_ANS_O.pop       = pop_ok;
        CORE_ANS_O.wake      = state_q == irq_ctrl_pkg::ST_SLEEP && any_set;
    end
    assign STACK_PTR_O = sp_q[2:0];

    // read data captured in the setup phase, held through access
    // reads have no side effects, so capturing before the access edge is safe
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            case (PADDR_I)
                `OFS_GLOBAL_CTRL: prdata_q <= {24'h0, global_q};
                `OFS_GROUP_CTRL:  prdata_q <= {24'h0, group_q};
                `OFS_EDGE_SEL:    prdata_q <= {28'h0, edge_sel_q};
                `OFS_TIMER_MATCH: prdata_q <= {24'h0, timer_q};
                `OFS_EE_LOWVOLT:  prdata_q <= {24'h0, ee_lv_q};
                `OFS_STATUS:      prdata_q <= {16'h0, grp0_q, 2'h0, state_q, sp_q};
                `OFS_VECTOR_BASE: prdata_q <= {20'h0, vec_base_q};
                default:          prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // edge select register
    // a select of zero turns the pin's edge detection off
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            edge_sel_q <= 4'h0;
        end else if (wr_edge) begin
            edge_sel_q <= PWDATA_I[3:0];
        end
    end
endmodule

// ---- verification/irq_ctrl_sva.sv ----
// port-level checks of the interrupt controller
module irq_ctrl_sva (
    input wire logic                     CLK_I,
    input wire logic                     NRST_I,
    input wire logic                     PSEL_I,
    input wire logic                     PENABLE_I,
    input wire logic [11:0]              PADDR_I,
    input wire logic                     PSLVERR_O,
    input wire logic [1:0]               PIN_PULLUP_SEL_I,
    input wire logic [1:0]               PIN_PULLUP_EN_O,
    input wire irq_ctrl_pkg::core_req_t  CORE_REQ_I,
    input wire irq_ctrl_pkg::core_ans_t  CORE_ANS_O,
    input wire logic [2:0]               STACK_PTR_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // entry only at a boundary, saving the next pc
    a_push_at_boundary: assert property (
        CORE_ANS_O.push |-> CORE_REQ_I.insn_boundary
        && CORE_ANS_O.push_data == CORE_REQ_I.next_pc)
        else $error("push off boundary or wrong pc");
    a_vector_follows: assert property (
        CORE_ANS_O.push |=> CORE_ANS_O.load_pc && CORE_ANS_O.pc_value
        inside {12'h004, 12'h008, 12'h00C, 12'h010, 12'h014})
        else $error("no vector load after push");
    // global enable drops on entry, so no second entry follows in the next two cycles
    a_no_nesting: assert property (
        CORE_ANS_O.push |=> !CORE_ANS_O.push [*2])
        else $error("entry repeated");
    a_pop_on_return: assert property (
        CORE_ANS_O.pop |-> CORE_REQ_I.return_from_irq)
        else $error("pop without return");
    a_push_grows_sp: assert property (
        CORE_ANS_O.push && !CORE_ANS_O.pop
        |=> STACK_PTR_O == 3'($past(STACK_PTR_O) + 3'h1))
        else $error("push did not grow stack");
    a_pop_shrinks_sp: assert property (
        CORE_ANS_O.pop && !CORE_ANS_O.push
        |=> STACK_PTR_O == 3'($past(STACK_PTR_O) - 3'h1))
        else $error("pop did not shrink stack");
    a_pullup_kept: assert property (
        PIN_PULLUP_EN_O == PIN_PULLUP_SEL_I)
        else $error("pull-up select lost");
    a_unmapped_err: assert property (
        PSEL_I && PENABLE_I && PADDR_I > 12'h018 |-> PSLVERR_O)
        else $error("unmapped access not flagged");
endmodule

bind irq_ctrl irq_ctrl_sva u_sva (
    .CLK_I            (CLK_I),
    .NRST_I           (NRST_I),
    .PSEL_I           (PSEL_I),
    .PENABLE_I        (PENABLE_I),
    .PADDR_I          (PADDR_I),
    .PSLVERR_O        (PSLVERR_O),
    .PIN_PULLUP_SEL_I (PIN_PULLUP_SEL_I),
    .PIN_PULLUP_EN_O  (PIN_PULLUP_EN_O),
    .CORE_REQ_I       (CORE_REQ_I),
    .CORE_ANS_O       (CORE_ANS_O),
    .STACK_PTR_O      (STACK_PTR_O)
);

// ---- verification/core_model.sv ----
// core sequencer model with a shadow pc stack
module core_model (
    input  wire logic                    clk_i,
    input  wire irq_ctrl_pkg::core_ans_t ans_i,
    output irq_ctrl_pkg::core_req_t      req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] stack_q [$];
    logic [11:0] pc = 12'h000;
    int          wakes = 0;
    initial req_o = '0;
    // answers are combinational, so sample them at the edge that ends the cycle
    always @(posedge clk_i) begin
        if (ans_i.push)
            stack_q.push_back(ans_i.push_data);
        if (ans_i.load_pc)
            pc = ans_i.pc_value;
        if (ans_i.pop && stack_q.size() > 0)
            pc = stack_q.pop_back();
        if (ans_i.wake)
            wakes++;
    end
    // one-cycle request, then two spare edges so the mirror has settled
    task automatic issue(input logic [11:0] npc, input logic b, input logic r,
                         input logic s);
        req_o <= '{next_pc: npc, insn_boundary: b, return_from_irq: r, sleep: s};
        @(posedge clk_i);
        req_o <= '0;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ---- verification/vectored_interrupt_controller_test.sv ----
// self-checking bench for the interrupt controller
module vectored_interrupt_controller_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk = 1'b0;
    logic                    nrst = 1'b0;
    logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, err;
    logic [11:0]             paddr = 12'h000;
    logic [31:0]             pwdata = 32'h0, prdata, rd;
    logic [1:0]              pin = 2'h0, pull_sel = 2'h0, pull_en, irq_mode;
    logic [2:0]              tmatch = 3'h0, grp_evt = 3'h0, sp, tv;
    logic                    lowvolt = 1'b0, ee_done = 1'b0, pslverr;
    logic [11:0]             npc;
    irq_ctrl_pkg::core_req_t req;
    irq_ctrl_pkg::core_ans_t ans;
    logic [11:0]             ofs [2] = '{12'h00C, 12'h010};
    logic [31:0]             msk [2] = '{32'h77, 32'h33};
    integer                  seed;
    int                      n_errors = 0, samples_checked = 0, w0;
    always #20 clk = ~clk;
    irq_ctrl DUT (
        .CLK_I            (clk),
        .NRST_I           (nrst),
        .PSEL_I           (psel),
        .PENABLE_I        (penable),
        .PWRITE_I         (pwrite),
        .PADDR_I          (paddr),
        .PWDATA_I         (pwdata),
        .PRDATA_O         (prdata),
        .PREADY_O         (pready),
        .PSLVERR_O        (pslverr),
        .PIN_I            (pin),
        .PIN_PULLUP_SEL_I (pull_sel),
        .PIN_PULLUP_EN_O  (pull_en),
        .PIN_IRQ_MODE_O   (irq_mode),
        .TIMER_MATCH_I    (tmatch),
        .GROUP0_EVT_I     (grp_evt),
        .EEPROM_DONE_I    (ee_done),
        .LOWVOLT_I        (lowvolt),
        .CORE_REQ_I       (req),
        .CORE_ANS_O       (ans),
        .STACK_PTR_O      (sp)
    );
    core_model core (
        .clk_i (clk),
        .ans_i (ans),
        .req_o (req)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one transfer; the slave decides when it is done, bounded by a count
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // both pins move together; each passes a two-flop synchroniser
    task automatic pin_to(input logic v);
        pin <= {v, v};
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
    endtask
    task automatic pulse(input logic [2:0] v);
        tmatch <= v;
        @(posedge clk);
        tmatch <= 3'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic complete_run();
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial begin
        seed = 32'hE48F;
        pull_sel <= 2'($random(seed));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // reset image of the map, then an unmapped word
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            check(rd, (i == 6) ? 32'h4 : 32'h0);
        end
        apb(1'b0, 12'h01C, 32'h0);
        check({rd[31:1], err}, 32'h1);
        check(32'(pull_en), 32'(pull_sel));
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ofs[i], 32'hFF);
            apb(1'b0, ofs[i], 32'h0);
            check(rd, msk[i]);
            apb(1'b1, ofs[i], 32'h0);
        end
        apb(1'b1, 12'h004, 32'h0);
        // every edge mode on both pins
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h008, 32'(m * 5));
            apb(1'b1, 12'h000, 32'h6);
            check(32'(irq_mode), 32'h3);
            pin_to(1'b1);
            check(32'(rd[4]), 32'(m % 2));
            check(32'(rd[5]), 32'(m % 2));
            apb(1'b1, 12'h000, 32'h6);
            pin_to(1'b0);
            check(32'(rd[4]), 32'(m / 2));
            check(32'(rd[5]), 32'(m / 2));
        end
        tv = 3'($random(seed)) | 3'h1;
        pulse(tv);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'({tv, 4'h0}));
        apb(1'b0, 12'h004, 32'h0);
        check(32'(rd[5]), 32'h1);
        // flag without its enable, then enables without global: no entry
        apb(1'b1, 12'h000, 32'h11);
        check(32'(irq_mode), 32'h0);
        core.issue(12'h123, 1'b1, 1'b0, 1'b0);
        apb(1'b1, 12'h004, 32'h22);
        apb(1'b1, 12'h000, 32'h12);
        core.issue(12'h124, 1'b1, 1'b0, 1'b0);
        check(32'(core.stack_q.size()), 32'h0);
        npc = 12'($random(seed));
        apb(1'b1, 12'h000, 32'h13);
        core.issue(npc, 1'b1, 1'b0, 1'b0);
        check(32'(core.pc), 32'h4);
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        core.issue(npc + 12'h1, 1'b1, 1'b0, 1'b0);
        check(32'(core.pc), 32'h10);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h2);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'({tv, 4'h0}));
        pulse(tv);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h22);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'({tv, 4'h0}));
        repeat (2) core.issue(12'h0, 1'b0, 1'b1, 1'b0);
        check(32'(core.pc), 32'(npc));
        // eight entries fill the stack; a ninth waits for a pop
        apb(1'b1, 12'h004, 32'h0);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 12'h000, 32'h13);
            core.issue(12'($random(seed)), 1'b1, 1'b0, 1'b0);
        end
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h13);
        core.issue(12'h0, 1'b0, 1'b1, 1'b0);
        check(32'(sp), 32'h7);
        core.issue(npc, 1'b1, 1'b0, 1'b0);
        check(32'(core.stack_q.size()), 32'h8);
        check(32'(core.stack_q[7]), 32'(npc));
        repeat (8) core.issue(12'h0, 1'b0, 1'b1, 1'b0);
        // sleeping core wakes on low-voltage and eeprom events
        apb(1'b1, 12'h000, 32'h0);
        w0 = core.wakes;
        core.issue(12'h0, 1'b0, 1'b0, 1'b1);
        lowvolt <= 1'b1;
        ee_done <= 1'b1;
        for (int i = 0; i < 20 && core.wakes == w0; i++)
            @(posedge clk);
        check(32'(core.wakes > w0), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h40);
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h30);
        // group 0 members: flags land in the status word and raise the group flag
        grp_evt <= 3'h5;
        @(posedge clk);
        grp_evt <= 3'h0;
        apb(1'b0, 12'h014, 32'h0);
        check(rd, 32'h5000);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h50);
        complete_run();
    end
endmodule
